/* logic/psc_pkg.sv */
package psc_pkg;
    // register map (word offsets chosen locally, byte address = offset)
    localparam logic [7:0] PSC_SETTINGS_OFS = 8'h00;
    localparam logic [7:0] PSC_STATUS_OFS = 8'h04;
    localparam logic [7:0] PSC_PROTECT_OFS = 8'h08;
    // settings field positions
    localparam int PSC_MEM_SLEEP_INHIBIT_BIT = 26;
    localparam int PSC_LOOPBACK_BIT = 25;
    localparam int PSC_INIT_LOCK_BIT = 24;
    localparam int PSC_PRIO2_LSB = 18;
    localparam int PSC_PRIO2_W = 3;
    localparam int PSC_PORT_BASED_BIT = 8;
    // reset values
    localparam logic [2:0] PSC_PRIO2_RST = 3'h1;
    localparam logic [31:0] PSC_PROTECT_RST = 32'h0000_0000;
    localparam logic [31:0] PSC_WRITABLE_MASK = 32'h071C_0100;
    // buffer pool
    localparam int PSC_NUM_BUFFERS = 8;
    localparam int PSC_FREE_W = 4;
    localparam int PSC_NUM_LANES = 4;
endpackage : psc_pkg

/* logic/psc_credit_gate.sv */
// decides whether a priority 2 packet may go, from the free buffer count
module psc_credit_gate (
    // threshold code and state
    input wire logic [psc_pkg::PSC_PRIO2_W-1:0] threshold_i,
    input wire logic [psc_pkg::PSC_FREE_W-1:0] free_count_i,
    input wire logic single_lane_i,
    // decision
    output logic send_ok_o
);
    import psc_pkg::*;
    logic [PSC_FREE_W-1:0] need;
    // code k needs k+1 free buffers
    assign need = {1'b0, threshold_i} + 4'h1; // [RQ7]
    // only single-lane ports are gated by this threshold; others pass
    assign send_ok_o = !single_lane_i || (free_count_i >= need); // [RQ6] [RQ7]
endmodule // psc_credit_gate

/* logic/psc_top.sv */
// Operation
// [RQ1] With the memory sleep inhibit bit clear memories sleep in shutdown, set keeps them awake.
// [RQ2] With the loopback bit set transmit data returns to the receive path before the serializer.
// [RQ3] While the init lock bit is clear, writes to otherwise read-only registers are accepted.
// [RQ4] Once the init lock bit is set, writes to read-only registers are ignored.
// [RQ5] Software normally sets the init lock bit once after reset, after configuring.
// [RQ6] Bits 20-18 set the free buffers needed to send priority 2, single-lane ports only.
// [RQ7] Code k lets a packet go only when at least k+1 of the eight buffers are free.
// [RQ8] The buffering bit selects priority buffers when clear, port buffers when set.
// [RQ9] Reserved bits 31-27 and 23-21 read as zero and ignore writes.
module psc_top (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // shutdown and memory sleep
    input wire logic SHUTDOWN_I,
    output logic MEM_SLEEP_O,
    // transmit and receive datapath
    input wire logic [31:0] TX_DATA_I,
    input wire logic TX_VALID_I,
    input wire logic [31:0] SERDES_RX_DATA_I,
    input wire logic SERDES_RX_VALID_I,
    output logic [31:0] SERDES_TX_DATA_O,
    output logic SERDES_TX_VALID_O,
    output logic [31:0] RX_DATA_O,
    output logic RX_VALID_O,
    // buffer credit
    input wire logic [psc_pkg::PSC_FREE_W-1:0] FREE_BUFFERS_I,
    input wire logic SINGLE_LANE_I,
    output logic PRIO2_SEND_OK_O,
    output logic PORT_BASED_O
);
    import psc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // settings register state
    logic mem_sleep_inhibit_r;
    logic loopback_r;
    logic init_lock_r;
    logic [PSC_PRIO2_W-1:0] prio2_threshold_r;
    logic port_based_r;
    logic [31:0] protect_r;
    logic [31:0] settings_value;
    logic [31:0] rdata_nxt;
    logic prio2_ok;
    logic wr_settings;
    logic [31:0] status_value;
    logic any_free;

    assign wr_settings = WR_I && (ADDR_I == PSC_SETTINGS_OFS);

    ////////////////////////////////////////////////////////////////////////
    // settings fields, one process each; reserved bits have no storage, so a write
    // to them leaves nothing behind and they always read back as zero
    // memory sleep inhibit
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            mem_sleep_inhibit_r <= 1'b0;
        end else if (wr_settings) begin // [RQ9]
            mem_sleep_inhibit_r <= WDATA_I[PSC_MEM_SLEEP_INHIBIT_BIT]; // [RQ1]
        end
    end

    // loopback select
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            loopback_r <= 1'b0;
        end else if (wr_settings) begin // [RQ9]
            loopback_r <= WDATA_I[PSC_LOOPBACK_BIT]; // [RQ2]
        end
    end

    // init lock is sticky once set: only a reset reopens writes, so a stray
    // clearing write cannot unlock the read-only registers behind software's back
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            init_lock_r <= 1'b0;
        end else if (wr_settings) begin // [RQ9]
            init_lock_r <= init_lock_r | WDATA_I[PSC_INIT_LOCK_BIT]; // [RQ4]
        end
    end

    // priority 2 credit threshold code; comes out of reset at code one
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            prio2_threshold_r <= PSC_PRIO2_RST;
        end else if (wr_settings) begin // [RQ9]
            prio2_threshold_r <= WDATA_I[PSC_PRIO2_LSB +: PSC_PRIO2_W]; // [RQ6]
        end
    end

    // buffering mode for the single-lane buffer pool
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            port_based_r <= 1'b0;
        end else if (wr_settings) begin // [RQ9]
            port_based_r <= WDATA_I[PSC_PORT_BASED_BIT]; // [RQ8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a read-only style register that is writable only during init
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            protect_r <= PSC_PROTECT_RST;
        end else if (WR_I && (ADDR_I == PSC_PROTECT_OFS) && !init_lock_r) begin // [RQ3] [RQ4]
            protect_r <= WDATA_I;
        end
    end

    // reserved bits forced to zero on read
    always_comb begin
        settings_value = 32'h0000_0000; // [RQ9]
        settings_value[PSC_MEM_SLEEP_INHIBIT_BIT] = mem_sleep_inhibit_r;
        settings_value[PSC_LOOPBACK_BIT] = loopback_r;
        settings_value[PSC_INIT_LOCK_BIT] = init_lock_r;
        settings_value[PSC_PRIO2_LSB +: PSC_PRIO2_W] = prio2_threshold_r;
        settings_value[PSC_PORT_BASED_BIT] = port_based_r;
    end

    // status word: live pin levels beside the registered outputs; the any-free flag
    // looks at all count bits, since a full pool of eight has its low three bits clear
    assign any_free = (FREE_BUFFERS_I != '0);
    always_comb begin
        status_value = 32'h0000_0000;
        status_value[0] = SHUTDOWN_I;
        status_value[1] = SINGLE_LANE_I;
        status_value[2] = any_free;
        status_value[3] = PRIO2_SEND_OK_O; // [RQ7]
        status_value[4] = MEM_SLEEP_O; // [RQ1]
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (ADDR_I)
            PSC_SETTINGS_OFS: rdata_nxt = settings_value;
            PSC_STATUS_OFS: rdata_nxt = status_value;
            PSC_PROTECT_OFS: rdata_nxt = protect_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data stand for the one cycle after the strobe only; zero otherwise, so a
    // stale word can never be taken for a fresh answer
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            RDATA_O <= 32'h0000_0000;
        end else if (RD_I) begin
            RDATA_O <= rdata_nxt;
        end else begin
            RDATA_O <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory sleep: only during shutdown and only when not inhibited
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            MEM_SLEEP_O <= 1'b0;
        end else begin
            MEM_SLEEP_O <= SHUTDOWN_I && !mem_sleep_inhibit_r; // [RQ1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serializer transmit side; it idles while looping back, so nothing leaves
    // on the link during a self test
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            SERDES_TX_DATA_O <= 32'h0000_0000;
            SERDES_TX_VALID_O <= 1'b0;
        end else if (loopback_r) begin
            SERDES_TX_DATA_O <= 32'h0000_0000; // [RQ2]
            SERDES_TX_VALID_O <= 1'b0; // [RQ2]
        end else begin
            SERDES_TX_DATA_O <= TX_DATA_I;
            SERDES_TX_VALID_O <= TX_VALID_I;
        end
    end

    // receive side: transmit data turned round ahead of the serializer, or the
    // serializer's own receive data in normal operation
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            RX_DATA_O <= 32'h0000_0000;
            RX_VALID_O <= 1'b0;
        end else if (loopback_r) begin
            RX_DATA_O <= TX_DATA_I; // [RQ2]
            RX_VALID_O <= TX_VALID_I; // [RQ2]
        end else begin
            RX_DATA_O <= SERDES_RX_DATA_I;
            RX_VALID_O <= SERDES_RX_VALID_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // credit threshold gate
    psc_credit_gate u_gate (
        .threshold_i(prio2_threshold_r),
        .free_count_i(FREE_BUFFERS_I),
        .single_lane_i(SINGLE_LANE_I),
        .send_ok_o(prio2_ok)
    );

    // send permission registered so the output comes straight from a flop
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            PRIO2_SEND_OK_O <= 1'b0;
        end else begin
            PRIO2_SEND_OK_O <= prio2_ok; // [RQ6] [RQ7]
        end
    end

    // buffering mode shown on a pin for the buffer pool logic
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            PORT_BASED_O <= 1'b0;
        end else begin
            PORT_BASED_O <= port_based_r; // [RQ8]
        end
    end
endmodule // psc_top

/* tb/psc_sva.sv */
module psc_checker
    import psc_pkg::*;
(
    // watched ports
    input wire logic CLK_I, SYS_RST_I, WR_I, RD_I, SHUTDOWN_I, TX_VALID_I, SERDES_RX_VALID_I,
    input wire logic SINGLE_LANE_I, MEM_SLEEP_O, SERDES_TX_VALID_O, RX_VALID_O,
    input wire logic PRIO2_SEND_OK_O, PORT_BASED_O,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I, RDATA_O,
    input wire logic [PSC_FREE_W-1:0] FREE_BUFFERS_I
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] sr, pv;
    logic up;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // shadows; up hides the first edge after reset, when outputs still show reset values
    always_ff @(posedge CLK_I) begin
        up <= !SYS_RST_I;
        if (SYS_RST_I) begin
            sr <= 32'h0004_0000;
            pv <= PSC_PROTECT_RST;
        end else if (WR_I && ADDR_I == PSC_SETTINGS_OFS) begin
            sr <= (WDATA_I & PSC_WRITABLE_MASK) | (sr & 32'h0100_0000);
        end else if (WR_I && ADDR_I == PSC_PROTECT_OFS && !sr[24]) begin
            pv <= WDATA_I;
        end
    end
    sequence s_rd(logic [7:0] a); RD_I && ADDR_I == a; endsequence
    property p_rsvd; s_rd(PSC_SETTINGS_OFS) |=> RDATA_O == $past(sr); endproperty
    property p_prot; s_rd(PSC_PROTECT_OFS) |=> RDATA_O == $past(pv); endproperty
    property p_sleep; up |-> MEM_SLEEP_O == $past(SHUTDOWN_I && !sr[26]); endproperty
    property p_loop; up |-> RX_VALID_O == $past(sr[25] ? TX_VALID_I : SERDES_RX_VALID_I);
    endproperty
    property p_idle; up |-> SERDES_TX_VALID_O == $past(TX_VALID_I && !sr[25]); endproperty
    property p_multi; up && $past(!SINGLE_LANE_I) |-> PRIO2_SEND_OK_O; endproperty
    property p_thr; up && $past(SINGLE_LANE_I) |->
        PRIO2_SEND_OK_O == ($past(FREE_BUFFERS_I) > $past(sr[20:18])); endproperty
    property p_port; up |-> PORT_BASED_O == $past(sr[8]); endproperty
    property p_stat; s_rd(PSC_STATUS_OFS) |=> RDATA_O == $past({27'h000_0000, MEM_SLEEP_O,
        PRIO2_SEND_OK_O, FREE_BUFFERS_I != 4'h0, SINGLE_LANE_I, SHUTDOWN_I}); endproperty
    a_rsvd: assert property (p_rsvd) else $error("settings read");
    a_prot: assert property (p_prot) else $error("protected read");
    a_sleep: assert property (p_sleep) else $error("sleep");
    a_loop: assert property (p_loop) else $error("rx path");
    a_idle: assert property (p_idle) else $error("tx path");
    a_multi: assert property (p_multi) else $error("multi lane");
    a_thr: assert property (p_thr) else $error("threshold");
    a_port: assert property (p_port) else $error("port mode");
    a_stat: assert property (p_stat) else $error("status read");
endmodule // psc_checker
bind psc_top psc_checker u_chk (.CLK_I, .SYS_RST_I, .WR_I, .RD_I, .SHUTDOWN_I, .TX_VALID_I,
    .SERDES_RX_VALID_I, .SINGLE_LANE_I, .MEM_SLEEP_O, .SERDES_TX_VALID_O, .RX_VALID_O,
    .PRIO2_SEND_OK_O, .PORT_BASED_O, .ADDR_I, .WDATA_I, .RDATA_O, .FREE_BUFFERS_I);

/* tb/peripheral_settings_control_tb.sv */
module peripheral_settings_control_tb;
    import psc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, wr, rd, shut, sleep, txv, srxv, stxv, rxv, sl, ok, pb;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, txd, srxd, stxd, rxd;
    logic [3:0] free;
    int failures, compares;
    psc_top DUT (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .SHUTDOWN_I(shut), .MEM_SLEEP_O(sleep), .TX_DATA_I(txd),
        .TX_VALID_I(txv), .SERDES_RX_DATA_I(srxd), .SERDES_RX_VALID_I(srxv),
        .SERDES_TX_DATA_O(stxd), .SERDES_TX_VALID_O(stxv), .RX_DATA_O(rxd), .RX_VALID_O(rxv),
        .FREE_BUFFERS_I(free), .SINGLE_LANE_I(sl), .PRIO2_SEND_OK_O(ok), .PORT_BASED_O(pb));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task chk(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // bus cycles: strobe for one cycle, read data land in the following cycle
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, e);
    endtask
    // register then derived output take one edge each
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task results;
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1; wr = 0; rd = 0; addr = 0; wdata = 0; shut = 1; sl = 0; free = 0;
        txv = 1; txd = 32'hA5A5_5A5A; srxv = 1; srxd = 32'h1234_5678;
        repeat (5) @(posedge clk);
        rst <= 0;
        rd_chk(PSC_SETTINGS_OFS, 32'h0004_0000);
        wr_reg(PSC_SETTINGS_OFS, 32'hFEFF_FFFF);
        rd_chk(PSC_SETTINGS_OFS, 32'h061C_0100);
        settle;
        chk(rxd, txd);
        chk(stxd, 32'h0000_0000);
        chk({ok, rxv, stxv, sleep, pb}, 32'h0000_0019);
        wr_reg(PSC_SETTINGS_OFS, 32'h0000_0000);
        settle;
        chk(rxd, srxd);
        chk(stxd, txd);
        chk({ok, rxv, stxv, sleep, pb}, 32'h0000_001E);
        @(posedge clk);
        sl <= 1;
        for (int k = 0; k < 8; k++) begin
            wr_reg(PSC_SETTINGS_OFS, 32'(k) << PSC_PRIO2_LSB);
            for (int f = 0; f <= PSC_NUM_BUFFERS; f++) begin
                @(posedge clk);
                free <= 4'(f);
                settle;
                chk({31'h0, ok}, {31'h0, f > k});
            end
        end
        // status with a full pool of eight, then with none free
        rd_chk(PSC_STATUS_OFS, 32'h0000_001F);
        @(posedge clk);
        free <= 4'h0;
        settle;
        rd_chk(PSC_STATUS_OFS, 32'h0000_0013);
        wr_reg(PSC_PROTECT_OFS, 32'hC0DE_0001);
        rd_chk(PSC_PROTECT_OFS, 32'hC0DE_0001);
        wr_reg(PSC_SETTINGS_OFS, 32'h0100_0000);
        wr_reg(PSC_PROTECT_OFS, 32'h0000_BEEF);
        rd_chk(PSC_PROTECT_OFS, 32'hC0DE_0001);
        wr_reg(PSC_SETTINGS_OFS, 32'h0000_0000);
        rd_chk(PSC_SETTINGS_OFS, 32'h0100_0000);
        wr_reg(8'hFC, 32'hFFFF_FFFF);
        rd_chk(8'hFC, 32'h0000_0000);
        // mid-run reset: the lock reopens and the protected word returns to zero
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rd_chk(PSC_SETTINGS_OFS, 32'h0004_0000);
        rd_chk(PSC_PROTECT_OFS, 32'h0000_0000);
        wr_reg(PSC_PROTECT_OFS, 32'h0000_BEEF);
        rd_chk(PSC_PROTECT_OFS, 32'h0000_BEEF);
        results;
    end
endmodule // peripheral_settings_control_tb
